// ---- sdcc_core.sv ----
// SDRAM command-mode, refresh and geometry/timing configuration with APB registers
//
// Operation
// - Mode 000: accesses decode as normal activate then read or write.
// - Mode 001: any access issues NOP.
// - Mode 010: any access issues precharge all banks.
// - Mode 011: access issues load mode register with access offset as value.
// - Mode 100: any access issues auto-refresh.
// - Mode 101: access issues extended load mode with offset as value.
// - Mode 110: device is put into deep power-down.
// - Twelve-bit refresh count loads a timer whose pulse starts a refresh.
// - No timer refresh until the refresh count is written; mode 100 accesses still issue auto-refresh.
// - Column field codes 00..11 give 8 to 11 column bits, reset 8.
// - Row field codes 00..10 give 11 to 13 row bits, 11 reserved.
// - Bank bit selects two banks at 0, four at 1.
// - CAS field codes 01..11 give latency 1..3, 00 reserved.
// - Bus width bit: 0 is 32-bit, 1 is 16-bit, reset 16.
// - Activate to read/write wait of 0..15 cycles.
// - Precharge to next command wait of 0..15 cycles.
// - Clock enable high to activate wait of 0..15 cycles.
`timescale 1ns/1ns
module sdcc_core (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire sdcc_pkg::sdcc_req_t   mem_req,
   output logic                       mem_ack,
   output sdcc_pkg::sdcc_sdram_t      sdram,
   output sdcc_pkg::sdcc_geom_t       geom
);
   import sdcc_pkg::*;

   typedef enum logic [2:0] {
      SDCC_ST_IDLE = 3'b000,
      SDCC_ST_WAIT = 3'b001,
      SDCC_ST_RW   = 3'b010,
      SDCC_ST_DONE = 3'b011,
      SDCC_ST_DPD  = 3'b100,
      SDCC_ST_XIT  = 3'b101
   } sdcc_fsm_t;

   typedef struct packed {
      logic [31:0] mode_r;
      logic [31:0] rfsh_r;
      logic [31:0] geom_r;
      logic        rfsh_wr;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      sdcc_fsm_t   fsm;
      sdcc_fsm_t   after;
      logic [3:0]  wait_cnt;
      logic        rfsh_pend;
      logic        mem_ack;
      sdcc_sdram_t sdram;
      sdcc_geom_t  geom;
   } sdcc_state_t;

   sdcc_state_t st_reg;
   sdcc_state_t st_next;
   logic        rfsh_pulse;

   sdcc_refresh_timer #(
      .CW (SDCC_COUNT_W)
   ) u_timer (
      .pclk          (pclk),
      .presetn       (presetn),
      .count_written (st_reg.rfsh_wr),
      .count         (st_reg.rfsh_r[SDCC_COUNT_W-1:0]),
      .pulse         (rfsh_pulse)
   );

   // Timing fields of the geometry/timing register
   logic [3:0]  f_a2rw;
   logic [3:0]  f_pre;
   logic [3:0]  f_r2a;
   logic [3:0]  f_srx;
   // Geometry fields
   logic [1:0]  f_nc;
   logic [1:0]  f_row;
   logic [1:0]  f_cas;
   sdcc_mode_t  mode;
   logic        apb_acc;
   logic [12:0] row_a;
   logic [12:0] col_a;
   logic [1:0]  bank_a;

   always_comb begin
      f_a2rw  = st_reg.geom_r[SDCC_A2RW_LSB +: 4];
      f_pre   = st_reg.geom_r[SDCC_PRE_LSB +: 4];
      f_r2a   = st_reg.geom_r[SDCC_R2A_LSB +: 4];
      f_srx   = st_reg.geom_r[SDCC_SRX_LSB +: 4];
      f_nc    = st_reg.geom_r[SDCC_NC_LSB +: 2];
      f_row   = st_reg.geom_r[SDCC_ROW_LSB +: 2];
      f_cas   = st_reg.geom_r[SDCC_CAS_LSB +: 2];
      mode    = sdcc_mode_t'(st_reg.mode_r[SDCC_MODE_W-1:0]);
      apb_acc = psel && penable && !st_reg.pready;
      // Column in low offset bits, bank next, row above
      col_a   = 13'(mem_req.offset & ((28'h1 << (SDCC_COL_BASE + int'(f_nc))) - 28'h1));
      bank_a  = 2'(mem_req.offset >> (SDCC_COL_BASE + int'(f_nc)));
      // Two-bank parts use a single bank bit
      if (!st_reg.geom_r[SDCC_BANK_BIT]) begin
         bank_a[1] = 1'b0;
      end
      row_a   = 13'(mem_req.offset >> (SDCC_COL_BASE + int'(f_nc)
                + (st_reg.geom_r[SDCC_BANK_BIT] ? 2 : 1)));
   end

   always_comb begin
      st_next           = st_reg;
      st_next.pready    = 1'b0;
      st_next.pslverr   = 1'b0;
      st_next.rfsh_wr   = 1'b0;
      st_next.mem_ack   = 1'b0;
      st_next.sdram.cmd = SDCC_CMD_NOP;

      // APB slave, one wait state
      if (apb_acc) begin
         st_next.pready = 1'b1;
         st_next.prdata = '0;
         case (paddr)
            SDCC_OFF_MODE: begin
               if (pwrite) st_next.mode_r = {29'h0, pwdata[SDCC_MODE_W-1:0]};
               st_next.prdata = st_reg.mode_r;
            end
            SDCC_OFF_RFSH: begin
               if (pwrite) begin
                  st_next.rfsh_r  = {20'h0, pwdata[SDCC_COUNT_W-1:0]};
                  st_next.rfsh_wr = 1'b1;
               end
               st_next.prdata = st_reg.rfsh_r;
            end
            SDCC_OFF_GEOM: begin
               if (pwrite) st_next.geom_r = pwdata;
               st_next.prdata = st_reg.geom_r;
            end
            SDCC_OFF_STAT: begin
               st_next.prdata = {27'h0, st_reg.rfsh_pend, st_reg.sdram.cke,
                                 st_reg.fsm};
            end
            default: st_next.pslverr = 1'b1;
         endcase
      end

      if (rfsh_pulse) st_next.rfsh_pend = 1'b1;

      // Geometry decode for the datapath
      st_next.geom.col_bits = 4'(SDCC_COL_BASE + int'(f_nc));
      // Reserved row code reads back as the smallest row count
      st_next.geom.row_bits = (f_row == 2'b11) ? 4'(SDCC_ROW_BASE)
                              : 4'(SDCC_ROW_BASE + int'(f_row));
      st_next.geom.banks    = st_reg.geom_r[SDCC_BANK_BIT] ? 3'h4 : 3'h2;
      st_next.geom.cas_lat  = f_cas;
      st_next.geom.bus16    = st_reg.geom_r[SDCC_WIDTH_BIT];

      case (st_reg.fsm)
         SDCC_ST_IDLE: begin
            if (st_reg.rfsh_pend && mode != SDCC_MODE_DPD) begin
               st_next.rfsh_pend = rfsh_pulse;
               st_next.sdram.cmd = SDCC_CMD_AREF;
               st_next.wait_cnt  = f_r2a;
               st_next.after     = SDCC_ST_IDLE;
               st_next.fsm       = SDCC_ST_WAIT;
            end else if (mode == SDCC_MODE_DPD) begin
               st_next.sdram.cmd = SDCC_CMD_DPD;
               st_next.sdram.cke = 1'b0;
               st_next.fsm       = SDCC_ST_DPD;
            end else if (mem_req.valid && !st_reg.mem_ack) begin
               // Request still held in the ack cycle is the finished one
               st_next.sdram.addr = 13'(mem_req.offset);
               st_next.sdram.ba   = '0;
               st_next.fsm        = SDCC_ST_DONE;
               case (mode)
                  SDCC_MODE_NOP:  st_next.sdram.cmd = SDCC_CMD_NOP;
                  SDCC_MODE_PALL: begin
                     st_next.sdram.cmd      = SDCC_CMD_PRE;
                     st_next.sdram.addr[10] = 1'b1;
                     st_next.wait_cnt       = f_pre;
                     st_next.after          = SDCC_ST_DONE;
                     st_next.fsm            = SDCC_ST_WAIT;
                  end
                  SDCC_MODE_LMR:  st_next.sdram.cmd = SDCC_CMD_LMR;
                  SDCC_MODE_AREF: begin
                     st_next.sdram.cmd = SDCC_CMD_AREF;
                     st_next.wait_cnt  = f_r2a;
                     st_next.after     = SDCC_ST_DONE;
                     st_next.fsm       = SDCC_ST_WAIT;
                  end
                  SDCC_MODE_EMR: begin
                     st_next.sdram.cmd = SDCC_CMD_LMR;
                     st_next.sdram.ba  = 2'b10;
                  end
                  default: begin
                     st_next.sdram.cmd  = SDCC_CMD_ACT;
                     st_next.sdram.addr = row_a;
                     st_next.sdram.ba   = bank_a;
                     st_next.wait_cnt   = f_a2rw;
                     st_next.after      = SDCC_ST_RW;
                     st_next.fsm        = SDCC_ST_WAIT;
                  end
               endcase
            end
         end
         SDCC_ST_WAIT: begin
            if (st_reg.wait_cnt == 4'h0) begin
               st_next.fsm = st_reg.after;
            end else begin
               st_next.wait_cnt = st_reg.wait_cnt - 4'h1;
            end
         end
         SDCC_ST_RW: begin
            st_next.sdram.cmd  = mem_req.write ? SDCC_CMD_WRITE : SDCC_CMD_READ;
            st_next.sdram.addr = col_a;
            st_next.fsm        = SDCC_ST_DONE;
         end
         SDCC_ST_DONE: begin
            st_next.mem_ack = 1'b1;
            st_next.fsm     = SDCC_ST_IDLE;
         end
         SDCC_ST_DPD: begin
            st_next.sdram.cmd = SDCC_CMD_DESEL;
            if (mode != SDCC_MODE_DPD) begin
               st_next.sdram.cke = 1'b1;
               st_next.wait_cnt  = f_srx;
               st_next.after     = SDCC_ST_IDLE;
               st_next.fsm       = SDCC_ST_WAIT;
            end
         end
         default: st_next.fsm = SDCC_ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg           <= '0;
         st_reg.mode_r    <= SDCC_MODE_RST;
         st_reg.rfsh_r    <= SDCC_RFSH_RST;
         st_reg.geom_r    <= SDCC_GEOM_RST;
         st_reg.fsm       <= SDCC_ST_IDLE;
         st_reg.after     <= SDCC_ST_IDLE;
         st_reg.sdram.cmd <= SDCC_CMD_NOP;
         st_reg.sdram.cke <= 1'b1;
         st_reg.geom      <= '{4'h8, 4'hB, 3'h2, 2'h2, 1'b1};
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata  = st_reg.prdata;
   assign pready  = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign mem_ack = st_reg.mem_ack;
   assign sdram   = st_reg.sdram;
   assign geom    = st_reg.geom;
endmodule

// ---- sdcc_core_test.sv ----
// Self-checking bench for the SDRAM command block
`timescale 1ns/1ns
module sdcc_core_test;
   import sdcc_pkg::*;
   localparam logic [3:0] ECMD [5] = '{SDCC_CMD_WRITE, SDCC_CMD_PRE, SDCC_CMD_LMR,
                                       SDCC_CMD_AREF, SDCC_CMD_LMR};
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_ack;
   logic        asleep, seq_err, err;
   logic [7:0]  paddr, n_ref, n0;
   logic [31:0] pwdata, prdata, rd, c;
   logic [3:0]  last_cmd;
   logic [12:0] mr, emr;
   sdcc_req_t   mem_req;
   sdcc_sdram_t sdram;
   sdcc_geom_t  geom;
   int          num_errors, check_count;
   sdcc_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .mem_req, .mem_ack, .sdram, .geom);
   sdcc_sdram_model i_mem (.pclk, .presetn, .sdram, .last_cmd, .mr, .emr, .n_ref,
      .asleep, .seq_err);
   initial pclk = 1'b0;
   always #10 pclk = ~pclk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20) chk(32'h0, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdx(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic acc(input logic w, input logic [27:0] off);
      int n;
      @(posedge pclk);
      mem_req <= '{1'b1, w, off};
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (mem_ack !== 1'b1 && n < 60);
      mem_req.valid <= 1'b0;
      if (n >= 60) chk(32'h0, 32'h1);
   endtask
   task automatic report_and_stop;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      report_and_stop;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      mem_req = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rdx(SDCC_OFF_MODE, SDCC_MODE_RST);
      rdx(SDCC_OFF_RFSH, SDCC_RFSH_RST);
      rdx(SDCC_OFF_GEOM, SDCC_GEOM_RST);
      chk(32'(geom), {18'h0, 4'h8, 4'hB, 3'h2, 2'h2, 1'b1});
      xfer(1'b0, 8'h10, 32'h0);
      chk(err, 1'b1);
      repeat (40) @(posedge pclk);
      chk(n_ref, 8'h0);
      // Column, row, bank, latency and width over their codes, activate wait fixed at 3
      for (int i = 0; i < 4; i++) begin
         c = {12'h853, 4'(i * 5), 8'h72, i[0], (i == 0) ? 2'h1 : 2'(i), i[0], 2'(i), 2'(i)};
         xfer(1'b1, SDCC_OFF_GEOM, c);
         rdx(SDCC_OFF_GEOM, c);
         chk(geom.col_bits, 4'h8 + 4'(i));
         chk(geom.row_bits, (i == 3) ? 4'hB : 4'hB + 4'(i));
         chk({geom.banks, geom.cas_lat, geom.bus16}, {i[0] ? 3'h4 : 3'h2, c[6:5], i[0]});
         acc(1'b0, 28'h0123 + 28'(i));
         chk(last_cmd, SDCC_CMD_READ);
         acc(1'b1, 28'h4567);
         chk(last_cmd, SDCC_CMD_WRITE);
      end
      // Precharge comes before auto-refresh in this order
      for (int m = 1; m < 6; m++) begin
         xfer(1'b1, SDCC_OFF_MODE, 32'(m));
         rdx(SDCC_OFF_MODE, 32'(m));
         acc(1'b0, 28'h0020 + 28'(m));
         acc(1'b1, 28'h0040 + 28'(m));
         chk(last_cmd, ECMD[m-1]);
         if (m == 2) chk(sdram.addr[10], 1'b1);
      end
      chk(mr, 13'h0043);
      chk(emr, 13'h0045);
      xfer(1'b1, SDCC_OFF_MODE, 32'h0);
      n0 = n_ref;
      xfer(1'b1, SDCC_OFF_RFSH, 32'h28);
      rdx(SDCC_OFF_RFSH, 32'h28);
      repeat (200) @(posedge pclk);
      chk((n_ref - n0) inside {8'h4, 8'h5}, 1'b1);
      xfer(1'b1, SDCC_OFF_RFSH, 32'h0);
      repeat (20) @(posedge pclk);
      n0 = n_ref;
      repeat (100) @(posedge pclk);
      chk(n_ref, n0);
      xfer(1'b1, SDCC_OFF_MODE, 32'h6);
      repeat (10) @(posedge pclk);
      chk({asleep, sdram.cke}, 2'b10);
      xfer(1'b1, SDCC_OFF_MODE, 32'h0);
      acc(1'b0, 28'h0);
      chk({last_cmd, sdram.cke}, {SDCC_CMD_READ, 1'b1});
      chk(seq_err, 1'b0);
      report_and_stop;
   end
endmodule

// ---- sdcc_monitor.sv ----
// Checker of the SDRAM command block ports
`timescale 1ns/1ns
module sdcc_monitor (
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [7:0]            paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire sdcc_pkg::sdcc_req_t   mem_req,
   input wire logic                  mem_ack,
   input wire sdcc_pkg::sdcc_sdram_t sdram,
   input wire sdcc_pkg::sdcc_geom_t  geom
);
   import sdcc_pkg::*;
   logic        wr;
   logic        rf_wr;
   logic [2:0]  mode_sh;
   logic [31:0] cfg_sh;
   logic [4:0]  cnt;
   assign wr = psel && penable && pready && pwrite;
   // Shadow copies of the written registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_sh <= 3'h0;
         cfg_sh <= SDCC_GEOM_RST;
         rf_wr <= 1'b0;
         cnt <= 5'h0;
      end else begin
         if (wr && paddr == SDCC_OFF_MODE) mode_sh <= pwdata[2:0];
         if (wr && paddr == SDCC_OFF_GEOM) cfg_sh <= pwdata;
         if (wr && paddr == SDCC_OFF_RFSH) rf_wr <= 1'b1;
         cnt <= (sdram.cmd == SDCC_CMD_ACT) ? 5'h0 : cnt + 5'h1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_RW_DIR: assert property (sdram.cmd inside {SDCC_CMD_READ, SDCC_CMD_WRITE}
      |-> (sdram.cmd == SDCC_CMD_WRITE) == mem_req.write) else $error("wrong direction");
   AST_NOP_ACK: assert property ($rose(mem_req.valid) && mode_sh == 3'h1 && !rf_wr
      |=> !mem_ack ##1 mem_ack) else $error("nop access timing");
   AST_MODE_LOAD: assert property (sdram.cmd == SDCC_CMD_LMR
      |-> sdram.addr == mem_req.offset[12:0] && sdram.ba == (mode_sh == 3'h5 ? 2'h2 : 2'h0))
      else $error("mode load value");
   AST_DPD: assert property (sdram.cmd == SDCC_CMD_DPD |-> mode_sh == 3'h6)
      else $error("power-down outside its mode");
   AST_NO_RFSH: assert property (sdram.cmd == SDCC_CMD_AREF |-> rf_wr || mode_sh == 3'h4)
      else $error("refresh before count written");
   AST_GEOM_SIZE: assert property ($stable(cfg_sh) |-> geom.col_bits == 4'h8 + cfg_sh[1:0]
      && geom.row_bits == (cfg_sh[3:2] == 2'h3 ? 4'hB : 4'hB + cfg_sh[3:2])
      && geom.banks == (cfg_sh[4] ? 3'h4 : 3'h2)) else $error("geometry decode");
   AST_GEOM_BUS: assert property ($stable(cfg_sh) |-> geom.cas_lat == cfg_sh[6:5]
      && geom.bus16 == cfg_sh[7]) else $error("latency or width decode");
   AST_ACT_WAIT: assert property (sdram.cmd inside {SDCC_CMD_READ, SDCC_CMD_WRITE}
      |-> cnt == {1'b0, cfg_sh[23:20]} + 5'h1) else $error("activate wait");
   cover property (sdram.cmd == SDCC_CMD_LMR);
   cover property (sdram.cmd == SDCC_CMD_AREF && mode_sh == 3'h0);
   cover property (pready && pslverr);
endmodule
bind sdcc_core sdcc_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_ack, .sdram, .geom);

// ---- sdcc_pkg.sv ----
// Package: register map, field layout, command codes and structs for the SDRAM command block
package sdcc_pkg;

   localparam logic [7:0]  SDCC_OFF_MODE   = 8'h00;
   localparam logic [7:0]  SDCC_OFF_RFSH   = 8'h04;
   localparam logic [7:0]  SDCC_OFF_GEOM   = 8'h08;
   localparam logic [7:0]  SDCC_OFF_STAT   = 8'h0C;

   localparam logic [31:0] SDCC_MODE_RST   = 32'h00000000;
   localparam logic [31:0] SDCC_RFSH_RST   = 32'h00000000;
   localparam logic [31:0] SDCC_GEOM_RST   = 32'h852372C0;

   localparam int SDCC_MODE_W   = 3;
   localparam int SDCC_COUNT_W  = 12;
   localparam int SDCC_NC_LSB   = 0;
   localparam int SDCC_ROW_LSB   = 2;
   localparam int SDCC_BANK_BIT  = 4;
   localparam int SDCC_CAS_LSB   = 5;
   localparam int SDCC_WIDTH_BIT = 7;
   localparam int SDCC_WREC_LSB  = 8;
   localparam int SDCC_R2A_LSB   = 12;
   localparam int SDCC_PRE_LSB   = 16;
   localparam int SDCC_A2RW_LSB  = 20;
   localparam int SDCC_A2P_LSB   = 24;
   localparam int SDCC_SRX_LSB   = 28;

   localparam int SDCC_COL_BASE = 8;
   localparam int SDCC_ROW_BASE = 11;

   typedef enum logic [2:0] {
      SDCC_MODE_NORMAL = 3'b000,
      SDCC_MODE_NOP    = 3'b001,
      SDCC_MODE_PALL   = 3'b010,
      SDCC_MODE_LMR    = 3'b011,
      SDCC_MODE_AREF   = 3'b100,
      SDCC_MODE_EMR    = 3'b101,
      SDCC_MODE_DPD    = 3'b110
   } sdcc_mode_t;

   // Command on the SDRAM pins: cs_n, ras_n, cas_n, we_n
   typedef enum logic [3:0] {
      SDCC_CMD_DESEL = 4'b1111,
      SDCC_CMD_NOP   = 4'b0111,
      SDCC_CMD_ACT   = 4'b0011,
      SDCC_CMD_READ  = 4'b0101,
      SDCC_CMD_WRITE = 4'b0100,
      SDCC_CMD_PRE   = 4'b0010,
      SDCC_CMD_AREF  = 4'b0001,
      SDCC_CMD_LMR   = 4'b0000,
      SDCC_CMD_DPD   = 4'b0110
   } sdcc_cmd_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [27:0] offset;
   } sdcc_req_t;

   typedef struct packed {
      sdcc_cmd_t   cmd;
      logic [1:0]  ba;
      logic [12:0] addr;
      logic        cke;
   } sdcc_sdram_t;

   typedef struct packed {
      logic [3:0]  col_bits;
      logic [3:0]  row_bits;
      logic [2:0]  banks;
      logic [1:0]  cas_lat;
      logic        bus16;
   } sdcc_geom_t;

endpackage

// ---- sdcc_refresh_timer.sv ----
// Periodic refresh pulse generator reloaded from the programmed count
`timescale 1ns/1ns
module sdcc_refresh_timer #(
   parameter int CW = 12
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          count_written,
   input  wire logic [CW-1:0] count,
   output logic               pulse
);
   import sdcc_pkg::*;

   initial begin
      if (CW < 2 || CW > 16) $error("sdcc_refresh_timer: CW out of range");
   end

   typedef struct packed {
      logic          armed;
      logic [CW-1:0] cnt;
      logic          pulse;
   } sdcc_rt_state_t;

   sdcc_rt_state_t st_reg;
   sdcc_rt_state_t st_next;

   always_comb begin
      st_next       = st_reg;
      st_next.pulse = 1'b0;
      if (count_written) begin
         st_next.armed = (count != '0);
         st_next.cnt   = count;
      end else if (st_reg.armed) begin
         if (st_reg.cnt <= CW'(1)) begin
            st_next.pulse = 1'b1;
            st_next.cnt   = count;
         end else begin
            st_next.cnt = st_reg.cnt - CW'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pulse = st_reg.pulse;
endmodule

// ---- sdcc_sdram_model.sv ----
// Behavioural SDRAM device watching the command pins
`timescale 1ns/1ns
module sdcc_sdram_model (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire sdcc_pkg::sdcc_sdram_t sdram,
   output logic [3:0]                 last_cmd,
   output logic [12:0]                mr,
   output logic [12:0]                emr,
   output logic [7:0]                 n_ref,
   output logic                       asleep,
   output logic                       seq_err
);
   import sdcc_pkg::*;
   logic idle;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_cmd <= SDCC_CMD_NOP;
         mr <= 13'h0;
         emr <= 13'h0;
         n_ref <= 8'h0;
         asleep <= 1'b0;
         seq_err <= 1'b0;
         idle <= 1'b1;
      end else begin
         if (sdram.cke && sdram.cmd != SDCC_CMD_DPD) asleep <= 1'b0;
         if (!(sdram.cmd inside {SDCC_CMD_NOP, SDCC_CMD_DESEL})) begin
            last_cmd <= sdram.cmd;
            if (!sdram.cke && sdram.cmd != SDCC_CMD_DPD) seq_err <= 1'b1;
            if (sdram.cmd == SDCC_CMD_DPD) asleep <= 1'b1;
            if (sdram.cmd == SDCC_CMD_LMR && sdram.ba == 2'h0) mr <= sdram.addr;
            if (sdram.cmd == SDCC_CMD_LMR && sdram.ba == 2'h2) emr <= sdram.addr;
            if (sdram.cmd == SDCC_CMD_AREF) n_ref <= n_ref + 8'h1;
            if (sdram.cmd == SDCC_CMD_AREF && !idle) seq_err <= 1'b1;
            if (sdram.cmd == SDCC_CMD_PRE && sdram.addr[10]) idle <= 1'b1;
            if (sdram.cmd == SDCC_CMD_ACT) idle <= 1'b0;
         end
      end
   end
endmodule
